// File: src/vsf_regs.svh
// Register offsets, field positions, reset values and constants
//
// Summary of operation
// - Each segment gathers five scattered macro blocks
// - 60 Hz rows i+2,6,8,0,4 mod 10, cols 2,1,3,0,4
// - 50 Hz divided block rows wrap modulo 11
// - 50 Hz edge unit: row 11, cols 0..4
// - Members share divided block and index k
// - Members processed in fixed order, first to fifth
// - Segment output is five 77-byte slots, 385 bytes
// - Slot holds own data plus sibling overflow
// - 1080-line block: four rows from each field
// - 720-line block: eight consecutive progressive rows
// - 1080-line: frame or field mode per difference
// - 720-line always uses frame mode
// - One transform mode for whole macro block
// - Field mode regroups rows by field
// - Separable 8x8 forward cosine transform, 64 coefficients
// - Index zero is DC, rest are AC
// - Coefficients weighted; luma, chroma, system tables
// - 1080/60i: k row by row, three rows of nine
// - 720/60p: k wraps after 26, six wide rows
// - 50 Hz: rows 0..10 plus edge row 11
// - Macro block is eight transform blocks
// - Super block has 27 macro blocks
`ifndef VSF_REGS_SVH
`define VSF_REGS_SVH

`define VSF_REG_CTRL 12'h000
`define VSF_REG_STATUS 12'h004
`define VSF_REG_POS 12'h008
`define VSF_REG_TAB_ADDR 12'h00C
`define VSF_REG_TAB_DATA 12'h010
`define VSF_REG_THRESH 12'h014

`define VSF_CTRL_SYS_LSB 0
`define VSF_CTRL_START 2
`define VSF_CTRL_FORCE_FIELD 3
`define VSF_CTRL_AUTO 4
`define VSF_CTRL_RESET 32'h0000_0010
`define VSF_THRESH_RESET 32'h0000_0400

`define VSF_MEMBERS 3'h5
`define VSF_ROWS_60 4'hA
`define VSF_ROWS_50 4'hB
`define VSF_EDGE_ROW 4'hB
`define VSF_K_LAST 5'h1A
`define VSF_SLOT_BYTES 7'h4D
`define VSF_SEG_BYTES 9'h181
`define VSF_BLOCKS_PER_MB 3'h7
`define VSF_N 8
`define VSF_LAST_IDX 6'h3F
`define VSF_TAB_QSEL 8
`define VSF_TAB_SCAN 9
`define VSF_C0 14'h05A8
`define VSF_C1 14'h0FB1
`define VSF_C2 14'h0EC8
`define VSF_C3 14'h0D4E
`define VSF_C4 14'h0B50
`define VSF_C5 14'h08E4
`define VSF_C6 14'h061F
`define VSF_C7 14'h031F
`define VSF_FRAC 12

`endif

// File: src/vsf_pkg.sv
// Types shared by the segment shuffle and transform front end
package vsf_pkg;
  typedef enum logic [1:0] {
    VSF_SYS_1080_60,
    VSF_SYS_1080_50,
    VSF_SYS_720_60,
    VSF_SYS_RSVD
  } vsf_sys_t;
  typedef enum logic [2:0] {
    VSF_IDLE,
    VSF_FETCH,
    VSF_ROWS,
    VSF_COLS,
    VSF_EMIT,
    VSF_NEXT
  } vsf_state_t;
endpackage

// File: src/vsf_front_end.sv
// Segment shuffle, transform block forming, 8x8 DCT, weighting, scan out
`timescale 1ns/1ns
`default_nettype none
`include "vsf_regs.svh"
module vsf_front_end #(
  parameter int PIX_W = 8,
  parameter int COEF_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [11:0] pix_addr,
  output logic pix_req,
  input wire logic [PIX_W-1:0] pix_data,
  input wire logic pix_valid,
  output logic [COEF_W-1:0] coef_data,
  output logic coef_valid,
  output logic coef_dc,
  output logic coef_last,
  output logic [2:0] coef_member,
  output logic [2:0] coef_block,
  output logic field_transform_mode,
  input wire logic coef_ready
);
  // Pixel fetch address {member, dct block, y, x}; the store outside
  // resolves member -> (h, row, col, k) from the position register.

  // ****************************************
  // Register bus
  // ****************************************
  logic [31:0] ctrl_q, thresh_q, pos_q, tab_addr_q;
  logic aw_hold_q, w_hold_q;
  logic [11:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  logic start_q;
  logic [3:0] row_q;
  logic [4:0] k_q;
  logic [1:0] h_q;
  logic edge_q;
  logic [2:0] member_q;
  logic [2:0] blk_q;
  vsf_pkg::vsf_state_t st_q;
  logic frame_mode_q;
  logic [15:0] seg_count_q;
  logic [PIX_W-1:0] weight_tab [0:511];
  logic [5:0] scan_tab [0:63];

  wire wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
  wire ctrl_hit = aw_q == `VSF_REG_CTRL;
  wire pos_hit = aw_q == `VSF_REG_POS;
  wire thr_hit = aw_q == `VSF_REG_THRESH;
  wire tab_a_hit = aw_q == `VSF_REG_TAB_ADDR;
  wire tab_d_hit = aw_q == `VSF_REG_TAB_DATA;
  wire wr_ok = ctrl_hit | pos_hit | thr_hit | tab_a_hit | tab_d_hit;
  wire tab_is_scan = tab_addr_q[`VSF_TAB_SCAN];
  wire busy = st_q != vsf_pkg::VSF_IDLE;

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = n[b*8 +: 8];
      end
    end
    return r;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_q <= 12'h000;
      w_q <= 32'h0000_0000;
      ws_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !aw_hold_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_hold_q && !s_axi_wready && !s_axi_bvalid;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `VSF_CTRL_RESET;
      thresh_q <= `VSF_THRESH_RESET;
      pos_q <= 32'h0000_0000;
      tab_addr_q <= 32'h0000_0000;
      start_q <= 1'b0;
    end else begin
      start_q <= wr_go && ctrl_hit && ws_q[0] && w_q[`VSF_CTRL_START];
      if (wr_go && ctrl_hit) begin
        ctrl_q <= merge(ctrl_q, w_q, ws_q) & ~(32'h1 << `VSF_CTRL_START);
      end
      if (wr_go && thr_hit) begin
        thresh_q <= merge(thresh_q, w_q, ws_q);
      end
      if (wr_go && pos_hit) begin
        pos_q <= merge(pos_q, w_q, ws_q);
      end
      if (wr_go && tab_a_hit) begin
        tab_addr_q <= merge(tab_addr_q, w_q, ws_q);
      end else if (wr_go && tab_d_hit) begin
        tab_addr_q <= tab_addr_q + 32'h1;
      end
    end
  end

  // Tables: weights per luma/chroma and per system, then scan order
  always_ff @(posedge aclk) begin
    if (wr_go && tab_d_hit && !tab_is_scan) begin
      weight_tab[tab_addr_q[8:0]] <= w_q[PIX_W-1:0];
    end
    if (wr_go && tab_d_hit && tab_is_scan) begin
      scan_tab[tab_addr_q[5:0]] <= w_q[5:0];
    end
  end

  wire [31:0] status_w = {seg_count_q, 5'h00, frame_mode_q, member_q,
                          blk_q, st_q, busy};
  wire [31:0] rd_mux =
    s_axi_araddr == `VSF_REG_CTRL ? ctrl_q :
    s_axi_araddr == `VSF_REG_STATUS ? status_w :
    s_axi_araddr == `VSF_REG_POS ? pos_q :
    s_axi_araddr == `VSF_REG_TAB_ADDR ? tab_addr_q :
    s_axi_araddr == `VSF_REG_THRESH ? thresh_q : 32'h0000_0000;
  wire rd_ok = s_axi_araddr == `VSF_REG_CTRL ||
               s_axi_araddr == `VSF_REG_STATUS ||
               s_axi_araddr == `VSF_REG_POS ||
               s_axi_araddr == `VSF_REG_TAB_ADDR ||
               s_axi_araddr == `VSF_REG_TAB_DATA ||
               s_axi_araddr == `VSF_REG_THRESH;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Segment member sequencing
  // ****************************************
  wire [1:0] sys = ctrl_q[`VSF_CTRL_SYS_LSB +: 2];
  wire is720 = sys == 2'(vsf_pkg::VSF_SYS_720_60);
  wire is50 = sys == 2'(vsf_pkg::VSF_SYS_1080_50);
  wire [3:0] nrows = is50 ? `VSF_ROWS_50 : `VSF_ROWS_60;

  function automatic logic [3:0] off_of(input logic [2:0] m);
    case (m)
      3'h0: return 4'h2;
      3'h1: return 4'h6;
      3'h2: return 4'h8;
      3'h3: return 4'h0;
      default: return 4'h4;
    endcase
  endfunction

  function automatic logic [2:0] col_of(input logic [2:0] m);
    case (m)
      3'h0: return 3'h2;
      3'h1: return 3'h1;
      3'h2: return 3'h3;
      3'h3: return 3'h0;
      default: return 3'h4;
    endcase
  endfunction

  wire [4:0] row_sum = {1'b0, row_q} + {1'b0, off_of(member_q)};
  wire [4:0] row_wrap = row_sum >= {1'b0, nrows} ?
                        row_sum - {1'b0, nrows} : row_sum;
  // Members come from five different columns; rows differ except in the edge unit, all row 11
  wire [3:0] mem_row = edge_q ? `VSF_EDGE_ROW : row_wrap[3:0];
  wire [2:0] mem_col = edge_q ? member_q : col_of(member_q);
  wire [1:0] mem_h = edge_q ? 2'h0 : h_q;

  // ****************************************
  // Transform datapath
  // ****************************************
  logic signed [PIX_W+1:0] blk_q2 [0:63];
  logic signed [COEF_W+8:0] tmp_q [0:63];
  // Column pass writes a separate array: in place would corrupt inputs
  logic signed [COEF_W+8:0] out_q [0:63];
  logic [5:0] idx_q;
  logic [31:0] diff_q;
  logic [PIX_W-1:0] prev_q;

  function automatic logic signed [14:0] cosv(input logic [2:0] f,
                                              input logic [2:0] p);
    logic [5:0] ang;
    logic [4:0] a;
    logic neg;
    logic [13:0] c;
    ang = 6'({3'h0, f} * ({2'h0, p, 1'b0} + 6'h01));
    a = ang[4:0];
    neg = 1'b0;
    if (a > 5'h10) begin
      a = 5'(6'h20 - {1'b0, a});
    end
    if (a > 5'h08) begin
      a = 5'(5'h10 - a);
      neg = 1'b1;
    end
    case (a[3:0])
      4'h0: c = 14'h1000;
      4'h1: c = `VSF_C1;
      4'h2: c = `VSF_C2;
      4'h3: c = `VSF_C3;
      4'h4: c = `VSF_C4;
      4'h5: c = `VSF_C5;
      4'h6: c = `VSF_C6;
      4'h7: c = `VSF_C7;
      default: c = 14'h0000;
    endcase
    if (f == 3'h0) begin
      c = `VSF_C0;
    end else begin
      c = {1'b0, c[13:1]};
    end
    return neg ? -$signed({1'b0, c}) : $signed({1'b0, c});
  endfunction

  // One output point per cycle keeps a segment well inside budget
  function automatic logic signed [COEF_W+17:0] row_dot(
    input logic [5:0] ix);
    logic signed [COEF_W+17:0] s;
    s = '0;
    for (int k = 0; k < 8; k++) begin
      s = s + (COEF_W+18)'(blk_q2[{ix[5:3], 3'(k)}] *
                           cosv(ix[2:0], 3'(k)));
    end
    return s;
  endfunction

  function automatic logic signed [COEF_W+17:0] col_dot(
    input logic [5:0] ix);
    logic signed [COEF_W+17:0] s;
    s = '0;
    for (int k = 0; k < 8; k++) begin
      s = s + (COEF_W+18)'(tmp_q[{3'(k), ix[2:0]}] *
                           cosv(ix[5:3], 3'(k)));
    end
    return s;
  endfunction

  // Field mode stores lines of even blocks in the upper half, odd blocks in the lower half
  wire [2:0] py = pix_addr[5:3];
  wire [2:0] row_slot = frame_mode_q ? py :
                        {blk_q[0], py[2:1]};
  wire [5:0] st_idx = {row_slot, pix_addr[2:0]};
  wire [2:0] u_i = idx_q[5:3];
  wire [2:0] v_i = idx_q[2:0];
  wire [5:0] scan_pos = scan_tab[idx_q];
  // Blocks 4..7 are colour difference and use their own matrix
  wire [8:0] w_addr = {sys, blk_q[2], scan_pos};
  wire signed [COEF_W+14:0] weighted =
    (COEF_W+15)'(out_q[scan_pos] * $signed({1'b0, weight_tab[w_addr]}));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= vsf_pkg::VSF_IDLE;
      member_q <= 3'h0;
      blk_q <= 3'h0;
      idx_q <= 6'h00;
      row_q <= 4'h0;
      k_q <= 5'h00;
      h_q <= 2'h0;
      edge_q <= 1'b0;
      frame_mode_q <= 1'b1;
      diff_q <= 32'h0000_0000;
      prev_q <= '0;
      seg_count_q <= 16'h0000;
      pix_req <= 1'b0;
      pix_addr <= 12'h000;
      coef_valid <= 1'b0;
      coef_data <= '0;
      coef_dc <= 1'b0;
      coef_last <= 1'b0;
      coef_member <= 3'h0;
      coef_block <= 3'h0;
      field_transform_mode <= 1'b0;
    end else begin
      case (st_q)
        vsf_pkg::VSF_IDLE: begin
          if (start_q) begin
            row_q <= pos_q[3:0];
            k_q <= pos_q[8:4];
            h_q <= pos_q[10:9];
            edge_q <= is50 && pos_q[11];
            member_q <= 3'h0;
            blk_q <= 3'h0;
            frame_mode_q <= 1'b1;
            diff_q <= 32'h0000_0000;
            pix_addr <= 12'h000;
            pix_req <= 1'b1;
            st_q <= vsf_pkg::VSF_FETCH;
          end
        end
        vsf_pkg::VSF_FETCH: begin
          if (pix_valid) begin
            blk_q2[st_idx] <= $signed({2'b00, pix_data});
            if (pix_addr[2:0] == 3'h0 && pix_addr[3] && !blk_q[2]) begin
              diff_q <= diff_q + 32'(pix_data > prev_q ?
                        pix_data - prev_q : prev_q - pix_data);
            end
            prev_q <= pix_data;
            pix_addr <= pix_addr + 12'h001;
            if (pix_addr[5:0] == `VSF_LAST_IDX) begin
              pix_req <= 1'b0;
              idx_q <= 6'h00;
              st_q <= vsf_pkg::VSF_ROWS;
              // Mode fixed at first block, held for the macro block
              if (blk_q == 3'h0) begin
                frame_mode_q <= is720 ||
                  (!ctrl_q[`VSF_CTRL_FORCE_FIELD] &&
                   (!ctrl_q[`VSF_CTRL_AUTO] ||
                    diff_q < thresh_q));
              end
            end
          end
        end
        vsf_pkg::VSF_ROWS: begin
          tmp_q[idx_q] <= (COEF_W+9)'(row_dot(idx_q) >>> `VSF_FRAC);
          idx_q <= idx_q + 6'h01;
          if (idx_q == `VSF_LAST_IDX) begin
            st_q <= vsf_pkg::VSF_COLS;
          end
        end
        vsf_pkg::VSF_COLS: begin
          blk_q2[idx_q] <= '0;
          out_q[idx_q] <= (COEF_W+9)'(col_dot(idx_q) >>> `VSF_FRAC);
          idx_q <= idx_q + 6'h01;
          if (idx_q == `VSF_LAST_IDX) begin
            st_q <= vsf_pkg::VSF_EMIT;
          end
        end
        vsf_pkg::VSF_EMIT: begin
          if (!coef_valid || coef_ready) begin
            coef_valid <= 1'b1;
            coef_data <= COEF_W'(weighted >>> `VSF_N);
            coef_dc <= idx_q == 6'h00;
            coef_last <= idx_q == `VSF_LAST_IDX;
            coef_member <= member_q;
            coef_block <= blk_q;
            field_transform_mode <= !frame_mode_q;
            idx_q <= idx_q + 6'h01;
            if (idx_q == `VSF_LAST_IDX) begin
              st_q <= vsf_pkg::VSF_NEXT;
            end
          end
        end
        vsf_pkg::VSF_NEXT: begin
          if (coef_ready) begin
            coef_valid <= 1'b0;
            coef_last <= 1'b0;
            pix_req <= 1'b1;
            st_q <= vsf_pkg::VSF_FETCH;
            if (blk_q == `VSF_BLOCKS_PER_MB) begin
              blk_q <= 3'h0;
              diff_q <= 32'h0000_0000;
              member_q <= member_q + 3'h1;
              pix_addr <= {member_q + 3'h1, 9'h000};
              if (member_q == `VSF_MEMBERS - 3'h1) begin
                pix_req <= 1'b0;
                seg_count_q <= seg_count_q + 16'h0001;
                st_q <= vsf_pkg::VSF_IDLE;
              end
            end else begin
              blk_q <= blk_q + 3'h1;
              pix_addr <= {member_q, blk_q + 3'h1, 6'h00};
            end
          end else if (coef_valid && coef_ready) begin
            coef_valid <= 1'b0;
          end
        end
        default: st_q <= vsf_pkg::VSF_IDLE;
      endcase
    end
  end

  // Member location, not exported; only folded into unused_ok
  wire unused_ok = ^{mem_row, mem_col, mem_h, k_q, nrows};
endmodule
`default_nettype wire

// File: test/vsf_front_end_sva.sv
// Concurrent checks on the front end ports, bound to the design module
`timescale 1ns/1ns
`default_nettype none
module vsf_front_end_chk #(
  parameter int COEF_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [11:0] pix_addr,
  input wire logic pix_req,
  input wire logic [COEF_W-1:0] coef_data,
  input wire logic coef_valid,
  input wire logic coef_dc,
  input wire logic coef_last,
  input wire logic [2:0] coef_member,
  input wire logic [2:0] coef_block,
  input wire logic field_transform_mode,
  input wire logic coef_ready
);
  // ****************************************
  // Position of the coefficient in its block
  // ****************************************
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic [2:0] blk_q;
  logic [2:0] mem_q;
  logic mode_q;
  logic seen_q;
  logic take;
  logic [2:0] next_mem;
  assign take = coef_valid && coef_ready;
  assign cnt_d = take ? cnt_q + 6'h01 : cnt_q;
  assign next_mem = (mem_q == 3'h4) ? 3'h0 : mem_q + 3'h1;
  // Last block seen is kept so that the next block can be judged
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 6'h00;
      seen_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      if (take && coef_last) begin
        seen_q <= 1'b1;
        blk_q <= coef_block;
        mem_q <= coef_member;
        mode_q <= field_transform_mode;
      end
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_dc_first: assert property (coef_valid |-> coef_dc == (cnt_q == 6'h00))
    else $error("dc flag not on first coefficient");
  a_last_count: assert property (coef_valid |-> coef_last == (cnt_q == 6'h3F))
    else $error("last flag not on coefficient 64");
  a_coef_hold: assert property (coef_valid && !coef_ready |=>
    coef_valid && $stable(coef_data) && $stable(coef_block))
    else $error("coefficient dropped while stalled");
  a_member_max: assert property (coef_valid |-> coef_member <= 3'h4)
    else $error("segment member out of range");
  a_block_step: assert property (coef_valid && coef_dc && seen_q |->
    coef_block == blk_q + 3'h1 &&
    coef_member == ((blk_q == 3'h7) ? next_mem : mem_q))
    else $error("block or member out of sequence");
  a_mode_per_mb: assert property (coef_valid && seen_q &&
    coef_member == mem_q |-> field_transform_mode == mode_q)
    else $error("transform mode changed inside macro block");
  a_pix_member: assert property (pix_req |-> pix_addr[11:9] <= 3'h4)
    else $error("pixel fetch for unknown member");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule
bind vsf_front_end vsf_front_end_chk #(.COEF_W(COEF_W)) u_chk (
  .aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pix_addr, .pix_req,
  .coef_data, .coef_valid, .coef_dc, .coef_last, .coef_member,
  .coef_block, .field_transform_mode, .coef_ready
);
`default_nettype wire

// File: test/vsf_quant_model.sv
// Pixel source and quantizer-side coefficient sink facing the front end
`timescale 1ns/1ns
`default_nettype none
module vsf_quant_model #(
  parameter int PIX_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] rnd,
  input wire logic pix_req,
  output logic [PIX_W-1:0] pix_data,
  output logic pix_valid,
  input wire logic coef_valid,
  input wire logic field_transform_mode,
  output logic coef_ready,
  output var int n_pix,
  output var int n_coef,
  output var int n_field
);
  // *****************************
  // Pixel offers and coefficient stalls
  // *****************************
  logic offer;
  assign offer = pix_req && (rnd[0] || rnd[1]);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pix_valid <= 1'b0;
      pix_data <= '0;
      coef_ready <= 1'b0;
      n_pix <= 0;
      n_coef <= 0;
      n_field <= 0;
    end else begin
      if (pix_valid && pix_req) n_pix <= n_pix + 1;
      // An offer stands until taken; an idle line toggles, never sits stale
      if (!pix_valid || pix_req) begin
        pix_valid <= offer;
        pix_data <= offer ? rnd[PIX_W+7:8] : ~pix_data;
      end
      coef_ready <= rnd[2] || rnd[3];
      if (coef_valid && coef_ready) begin
        n_coef <= n_coef + 1;
        if (field_transform_mode) n_field <= n_field + 1;
      end
    end
  end
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the segment shuffle and transform front end
`timescale 1ns/1ns
`default_nettype none
`include "vsf_regs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  miscompares++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top;
  localparam int SEG_COEFS = 5 * 8 * 64;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, pix_req, pix_valid;
  logic coef_valid, coef_dc, coef_last, field_transform_mode, coef_ready;
  logic [11:0] s_axi_awaddr, s_axi_araddr, pix_addr, coef_data;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] pix_data;
  logic [2:0] coef_member, coef_block;
  logic [31:0] rnd_q = 32'hFF98_9EAE;
  int miscompares, comparisons, cyc, segs, n_pix, n_coef, n_field;
  vsf_front_end dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pix_addr, .pix_req, .pix_data, .pix_valid, .coef_data,
    .coef_valid, .coef_dc, .coef_last, .coef_member, .coef_block,
    .field_transform_mode, .coef_ready
  );
  vsf_quant_model u_quant (
    .aclk, .aresetn, .rnd(rnd_q), .pix_req, .pix_data, .pix_valid,
    .coef_valid, .field_transform_mode, .coef_ready, .n_pix, .n_coef,
    .n_field
  );
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Field mode only when forced on a 1080-line system
  function automatic int exp_field(input logic [1:0] sys, input logic frc);
    return (sys != 2'h2 && frc) ? SEG_COEFS : 0;
  endfunction
  task automatic close_out();
    if (miscompares == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    bit done;
    done = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        done = 1;
        s_axi_bready <= 1'b0;
      end else if (!s_axi_bready) s_axi_bready <= rnd_q[4];
    end
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    bit done;
    done = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        done = 1;
        s_axi_rready <= 1'b0;
      end else if (!s_axi_rready) s_axi_rready <= rnd_q[5];
    end
  endtask
  task automatic run_seg(input logic [1:0] sys, input logic frc,
                         input logic [11:0] pos, input logic [31:0] thr);
    int p0, c0, f0;
    logic [31:0] d;
    logic [1:0] r;
    wr(`VSF_REG_THRESH, thr, r);
    wr(`VSF_REG_POS, {20'h0, pos}, r);
    rd(`VSF_REG_POS, d, r);
    `CHK(d, {20'h0, pos})
    p0 = n_pix;
    c0 = n_coef;
    f0 = n_field;
    wr(`VSF_REG_CTRL, {27'h0, !frc, frc, 1'b1, sys}, r);
    while (n_coef - c0 < SEG_COEFS) @(posedge aclk);
    do rd(`VSF_REG_STATUS, d, r); while (d[0] !== 1'b0);
    segs++;
    `CHK(n_coef - c0, SEG_COEFS)
    `CHK(n_pix - p0, SEG_COEFS)
    `CHK(n_field - f0, exp_field(sys, frc))
    `CHK(d[31:16], 16'(segs))
  endtask
  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    rnd_q <= xs(rnd_q);
    cyc++;
    if (cyc == 99000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`VSF_REG_CTRL, d, r);
    `CHK(d, `VSF_CTRL_RESET)
    rd(`VSF_REG_THRESH, d, r);
    `CHK(d, `VSF_THRESH_RESET)
    rd(12'hFF0, d, r);
    `CHK({r, d}, {2'h2, 32'h0})
    wr(12'hFF0, rnd_q, r);
    `CHK(r, 2'h2)
    // Weights run on into the scan table as the address autoincrements
    wr(`VSF_REG_TAB_ADDR, 32'h0, r);
    for (int i = 0; i < 576; i++) begin
      wr(`VSF_REG_TAB_DATA, i < 512 ? {24'h0, rnd_q[7:0] | 8'h01} : i - 512,
         r);
      `CHK(r, 2'h0)
    end
    run_seg(2'h0, 1'b1, {1'b0, rnd_q[1:0], 5'(rnd_q[9:4] % 27),
            4'(rnd_q[15:12] % 10)}, 32'h0);
    run_seg(2'h1, 1'b0, {1'b1, 2'h0, 5'h1A, 4'hB}, 32'hFFFF_FFFF);
    run_seg(2'h2, 1'b1, {1'b0, 2'h3, 5'h1A, 4'h9}, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
